// >>> rtl/scfp_core.sv
`timescale 1ns/1ps
`default_nettype none
module scfp_core #(
   parameter int              CACHE_BYTES = 4096,
   parameter bit              HAS_CACHE   = 1'b1,
   parameter int              N_TCM       = 0,
   parameter logic [4*31-1:0] TCM_BASE    = '0,
   parameter logic [4*31-1:0] TCM_MASK    = '0,
   parameter scfp_pkg::scfp_mul_t MUL_OPT = scfp_pkg::SCFP_MUL_EMB
) (
   input  wire logic                    ref_clk,
   input  wire logic                    rst,
   // Instruction master
   output logic [30:0]                  im_address,
   output logic                         im_read,
   input  wire logic                    im_waitrequest,
   input  wire logic                    im_readdatavalid,
   input  wire logic [31:0]             im_readdata,
   // Tightly coupled instruction ports
   output logic [4*31-1:0]              tcm_address,
   output logic [3:0]                   tcm_read,
   input  wire logic [4*32-1:0]         tcm_readdata,
   // Decode-side instruction class from the decoder
   input  wire scfp_pkg::scfp_op_t      dec_op,
   input  wire logic [31:0]             dec_disp,
   input  wire logic [5:0]              dec_shamt,
   input  wire logic [30:0]             dec_target,
   // Execute-side resolved branch outcome
   input  wire logic                    ex_taken,
   input  wire logic [30:0]             ex_target,
   // Cache maintenance address from execute
   input  wire logic [30:0]             cm_addr,
   // Data master handshake and custom stall
   input  wire logic                    dm_waitrequest,
   input  wire logic                    ci_stall,
   // Pipeline state
   output logic [4:0]                   stage_valid,
   output logic                         retire,
   output logic [31:0]                  fetch_word,
   output logic                         fetch_word_valid,
   output logic                         stall
);
   import scfp_pkg::*;
   // ******************************
   // Configuration checks
   // ******************************
   localparam int LINES  = CACHE_BYTES / (LINE_WORDS * 4);
   localparam int LINE_W = $clog2(LINES);
   localparam int TAG_W  = ADDR_W - LINE_W - LINE_OFS_W - WORD_OFS_LSB;
   initial begin
      if (!HAS_CACHE && N_TCM < 1)
         $error("core without cache needs a tightly coupled memory");
      if (N_TCM < 0 || N_TCM > MAX_TCM)
         $error("tightly coupled memory count out of range");
      if (CACHE_BYTES < 512 || CACHE_BYTES > 65536)
         $error("cache size out of range");
   end
   // ******************************
   // Address split
   // ******************************
   function automatic logic [LINE_W-1:0] line_of(input logic [30:0] a);
      return a[WORD_OFS_LSB+LINE_OFS_W +: LINE_W];
   endfunction : line_of
   function automatic logic [TAG_W-1:0] tag_of(input logic [30:0] a);
      return a[ADDR_W-1 -: TAG_W];
   endfunction : tag_of
   // ******************************
   // Pipeline registers
   // ******************************
   typedef enum logic [4:0] {
      SCFP_F_RUN  = 5'b00001,
      SCFP_F_FILL = 5'b00010,
      SCFP_F_TCM  = 5'b00100,
      SCFP_F_HOLD = 5'b01000,
      SCFP_F_IDLE = 5'b10000
   } scfp_fstate_t;
   scfp_fstate_t fst_q;
   logic [30:0]  pc_q;
   logic [4:0]   v_q;
   scfp_op_t     op_q [1:4];
   logic [30:0]  tgt_q [1:3];
   logic         pred_q [1:3];
   logic [5:0]   shamt_q [1:3];
   logic         stall_m;
   logic         redirect;
   logic [30:0]  redirect_pc;
   logic         fetch_ok;
   logic         ptake;
   logic [3:0]   tcm_sel_q;
   logic [3:0]   tcm_hit;
   logic [3:0]   cm_tcm_hit;
   scfp_stall_if sif ();
   scfp_tcm_decode #(.N_TCM(N_TCM), .BASE(TCM_BASE), .MASK(TCM_MASK))
      u_dec (.addr(pc_q), .hit(tcm_hit));
   scfp_tcm_decode #(.N_TCM(N_TCM), .BASE(TCM_BASE), .MASK(TCM_MASK))
      u_cmdec (.addr(cm_addr), .hit(cm_tcm_hit));
   scfp_mstage_timer u_tmr (.ref_clk(ref_clk), .rst(rst), .sif(sif));
   // ******************************
   // Memory-stage stall
   // ******************************
   // sole stall source
   always_comb begin
      stall_m = 1'b0;
      if (v_q[3]) begin
         case (op_q[3])
            SCFP_OP_LOAD, SCFP_OP_STORE: stall_m = dm_waitrequest;
            SCFP_OP_CUSTOM: stall_m = ci_stall;
            SCFP_OP_SHIFT, SCFP_OP_MUL: stall_m = sif.busy;
            default: stall_m = 1'b0;
         endcase
      end
   end
   logic m_first_q;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         m_first_q <= 1'b1;
      end else begin
         m_first_q <= !stall_m;
      end
   end
   // Timer loads on the first memory-stage cycle of each shift or multiply
   always_comb begin
      sif.start = v_q[3] && m_first_q &&
                  (op_q[3] == SCFP_OP_SHIFT || op_q[3] == SCFP_OP_MUL);
      sif.count = 6'h01;
      case (MUL_OPT)
         SCFP_MUL_EMB: sif.count = 6'(MUL_EMB_CYCLES);
         SCFP_MUL_LE:  sif.count = 6'(MUL_LE_CYCLES);
         default:
            sif.count = (op_q[3] == SCFP_OP_SHIFT) ?
                        ((shamt_q[3] == 6'h00) ? 6'h01 : shamt_q[3]) : 6'h01;
      endcase
   end
   // ******************************
   // Redirects and flushes
   // ******************************
   // Resolved in execute so the flush cancels F, D and the E slot behind it
   always_comb begin
      redirect    = 1'b0;
      redirect_pc = 31'h0000_0000;
      if (v_q[2] && !stall_m) begin
         case (op_q[2])
            SCFP_OP_BRANCH: begin
               redirect    = (ex_taken != pred_q[2]);
               redirect_pc = ex_taken ? ex_target : tgt_q[2];
            end
            SCFP_OP_FLUSH, SCFP_OP_JUMP, SCFP_OP_CACHE: begin
               redirect    = 1'b1;
               redirect_pc = (op_q[2] == SCFP_OP_JUMP) ? ex_target : tgt_q[2];
            end
            default: begin
               redirect    = 1'b0;
               redirect_pc = 31'h0000_0000;
            end
         endcase
      end
   end
   // predicted-taken bubble
   // A backward branch in fetch steers the next fetch to its target
   assign ptake = v_q[0] && !stall_m && !redirect &&
                  (fst_q == SCFP_F_RUN || fst_q == SCFP_F_TCM ||
                   fst_q == SCFP_F_HOLD) &&
                  dec_op == SCFP_OP_BRANCH && dec_disp[31];
   // ******************************
   // Stage valid bits
   // ******************************
   // in-order advance
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         v_q <= 5'h00;
      end else if (stall_m) begin
         v_q <= {1'b0, v_q[3:0]};
      end else begin
         v_q[4] <= v_q[3];
         v_q[3] <= v_q[2];
         v_q[2] <= v_q[1] && !redirect;
         v_q[1] <= v_q[0] && !redirect;
         v_q[0] <= fetch_ok && !redirect && !ptake;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!stall_m) begin
         op_q[4]    <= op_q[3];
         op_q[3]    <= op_q[2];
         op_q[2]    <= op_q[1];
         tgt_q[3]   <= tgt_q[2];
         tgt_q[2]   <= tgt_q[1];
         pred_q[3]  <= pred_q[2];
         pred_q[2]  <= pred_q[1];
         shamt_q[3] <= shamt_q[2];
         shamt_q[2] <= shamt_q[1];
         op_q[1]    <= dec_op;
         shamt_q[1] <= dec_shamt;
         pred_q[1]  <= (dec_op == SCFP_OP_BRANCH) && dec_disp[31];
         tgt_q[1]   <= pc_q;
      end
   end
   // ******************************
   // Instruction cache
   // ******************************
   logic [31:0]       dat_q [LINES*LINE_WORDS];
   logic [TAG_W-1:0]  tag_q [LINES];
   logic [LINES-1:0]  lval_q;
   logic              hit;
   logic [LINE_OFS_W-1:0] req_ofs_q;
   logic [LINE_OFS_W-1:0] rsp_ofs_q;
   logic [3:0]        req_cnt_q;
   logic [3:0]        rsp_cnt_q;
   logic [30:0]       miss_pc_q;
   logic              crit_q;
   assign hit = HAS_CACHE && lval_q[line_of(pc_q)] &&
                (tag_q[line_of(pc_q)] == tag_of(pc_q));
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lval_q <= '0;
      end else if (v_q[2] && !stall_m && op_q[2] == SCFP_OP_CACHE &&
                   cm_tcm_hit == 4'h0) begin
         lval_q[line_of(cm_addr)] <= 1'b0;
      end else if (fst_q == SCFP_F_FILL && rsp_cnt_q == 4'(LINE_WORDS)) begin
         lval_q[line_of(miss_pc_q)] <= 1'b1;
      end
   end
   // ******************************
   // Fetch control
   // ******************************
   // TCM routes around cache
   // Tightly coupled spans stream one fetch per cycle with no cache lookup
   assign fetch_ok = !stall_m && ((fst_q != SCFP_F_FILL &&
                     fst_q != SCFP_F_IDLE && tcm_hit != 4'h0) ||
                     (fst_q == SCFP_F_RUN && tcm_hit == 4'h0 && hit) ||
                     (fst_q == SCFP_F_FILL && crit_q));
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fst_q     <= SCFP_F_IDLE;
         pc_q      <= RESET_ADDR;
         req_cnt_q <= 4'h0;
         rsp_cnt_q <= 4'h0;
         crit_q    <= 1'b0;
      end else begin
         crit_q <= 1'b0;
         case (fst_q)
            SCFP_F_IDLE: fst_q <= SCFP_F_RUN;
            SCFP_F_RUN, SCFP_F_TCM, SCFP_F_HOLD: begin
               if (redirect) begin
                  pc_q  <= redirect_pc;
                  fst_q <= SCFP_F_RUN;
               end else if (ptake) begin
                  pc_q  <= dec_target;
                  fst_q <= SCFP_F_RUN;
               end else if (fetch_ok) begin
                  pc_q  <= 31'(pc_q + 31'h4);
                  fst_q <= SCFP_F_RUN;
               end else if (tcm_hit != 4'h0) begin
                  fst_q <= stall_m ? SCFP_F_HOLD : SCFP_F_TCM;
               end else if (!hit && HAS_CACHE && fst_q != SCFP_F_HOLD) begin
                  fst_q     <= SCFP_F_FILL;
                  miss_pc_q <= pc_q;
                  req_ofs_q <= pc_q[WORD_OFS_LSB +: LINE_OFS_W];
                  rsp_ofs_q <= pc_q[WORD_OFS_LSB +: LINE_OFS_W];
                  req_cnt_q <= 4'h0;
                  rsp_cnt_q <= 4'h0;
               end else begin
                  fst_q <= SCFP_F_RUN;
               end
            end
            SCFP_F_FILL: begin
               if (im_read && !im_waitrequest) begin
                  req_ofs_q <= req_ofs_q + 3'h1;
                  req_cnt_q <= req_cnt_q + 4'h1;
               end
               if (im_readdatavalid) begin
                  dat_q[{line_of(miss_pc_q), rsp_ofs_q}] <= im_readdata;
                  rsp_ofs_q <= rsp_ofs_q + 3'h1;
                  rsp_cnt_q <= rsp_cnt_q + 4'h1;
                  if (rsp_cnt_q == 4'h0) begin
                     tag_q[line_of(miss_pc_q)] <= tag_of(miss_pc_q);
                  end
               end
               if (rsp_cnt_q == 4'(LINE_WORDS)) begin
                  fst_q <= SCFP_F_RUN;
               end
            end
            default: fst_q <= SCFP_F_RUN;
         endcase
      end
   end
   // ******************************
   // Bus outputs, registered
   // ******************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         im_read    <= 1'b0;
         im_address <= 31'h0000_0000;
      end else if (fst_q == SCFP_F_FILL) begin
         if (!im_read || !im_waitrequest) begin
            im_read    <= (req_cnt_q + 4'(im_read)) < 4'(LINE_WORDS);
            im_address <= {miss_pc_q[30:5],
                           3'(req_ofs_q + 3'(im_read)), 2'h0};
         end
      end else begin
         im_read <= 1'b0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tcm_read    <= 4'h0;
         tcm_address <= '0;
         tcm_sel_q   <= 4'h0;
      end else begin
         tcm_read    <= fetch_ok ? tcm_hit : 4'h0;
         tcm_address <= {4{pc_q}};
         // Slave answers one cycle after the read, so remember the port
         tcm_sel_q   <= tcm_read;
      end
   end
   logic [31:0] tcm_word;
   always_comb begin
      tcm_word = 32'h0000_0000;
      for (int i = 0; i < MAX_TCM; i++) begin
         if (tcm_sel_q[i]) tcm_word = tcm_readdata[i*32 +: 32];
      end
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fetch_word       <= 32'h0000_0000;
         fetch_word_valid <= 1'b0;
         stage_valid      <= 5'h00;
         retire           <= 1'b0;
         stall            <= 1'b0;
      end else begin
         fetch_word_valid <= (fetch_ok && !redirect && !ptake &&
                              tcm_hit == 4'h0) || (tcm_sel_q != 4'h0);
         fetch_word <= (tcm_sel_q != 4'h0) ? tcm_word :
                       dat_q[{line_of(pc_q), pc_q[4:2]}];
         stage_valid <= v_q;
         retire      <= v_q[3] && !stall_m;
         stall       <= stall_m;
      end
   end
endmodule : scfp_core
`default_nettype wire

// >>> inc/scfp_pkg.sv
package scfp_pkg;
   // ******************************
   // Address layout
   // ******************************
   localparam int ADDR_W        = 31;
   localparam int WORD_OFS_LSB  = 2;
   localparam int LINE_OFS_W    = 3;
   localparam int LINE_WORDS    = 8;
   localparam int MAX_TCM       = 4;
   localparam int DATA_W        = 32;
   localparam logic [ADDR_W-1:0] RESET_ADDR = 31'h0000_0000;
   // ******************************
   // Cycle costs
   // ******************************
   localparam int FLUSH_PENALTY  = 3;
   localparam int FLUSH_CYCLES   = 4;
   localparam int MUL_EMB_CYCLES = 3;
   localparam int MUL_LE_CYCLES  = 4;
   localparam int SERIAL_MAX     = 32;
   // ******************************
   // Multiplier options and instruction classes
   // ******************************
   typedef enum logic [1:0] {
      SCFP_MUL_NONE = 2'h0,
      SCFP_MUL_EMB  = 2'h1,
      SCFP_MUL_LE   = 2'h2
   } scfp_mul_t;
   typedef enum logic [3:0] {
      SCFP_OP_ALU    = 4'h0,
      SCFP_OP_BRANCH = 4'h1,
      SCFP_OP_FLUSH  = 4'h2,
      SCFP_OP_JUMP   = 4'h3,
      SCFP_OP_LOAD   = 4'h4,
      SCFP_OP_STORE  = 4'h5,
      SCFP_OP_SHIFT  = 4'h6,
      SCFP_OP_MUL    = 4'h7,
      SCFP_OP_CUSTOM = 4'h8,
      SCFP_OP_CACHE  = 4'h9
   } scfp_op_t;
endpackage : scfp_pkg

// >>> inc/scfp_stall_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scfp_stall_if;
   logic start;
   logic [5:0] count;
   logic busy;
   modport ctrl (output start, output count, input busy);
   modport unit (input start, input count, output busy);
endinterface : scfp_stall_if
`default_nettype wire

// >>> rtl/scfp_mstage_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Memory-stage occupancy timer for shifter and multiplier operations
module scfp_mstage_timer (
   input  wire logic   ref_clk,
   input  wire logic   rst,
   scfp_stall_if.unit  sif
);
   import scfp_pkg::*;
   logic [5:0] left_q;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         left_q <= 6'h00;
      end else if (sif.start) begin
         // The start cycle is the first of the count, so load one less
         left_q <= sif.count - 6'h01;
      end else if (left_q != 6'h00) begin
         left_q <= left_q - 6'h01;
      end
   end
   // Busy covers all but the final cycle of the operation
   assign sif.busy = sif.start ? (sif.count > 6'h01) : (left_q > 6'h01);
endmodule : scfp_mstage_timer
`default_nettype wire

// >>> rtl/scfp_tcm_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Fetch address decode across tightly coupled instruction spans
module scfp_tcm_decode #(
   parameter int                               N_TCM = 1,
   parameter logic [4*31-1:0]                  BASE  = '0,
   parameter logic [4*31-1:0]                  MASK  = '0
) (
   input  wire logic [30:0]                    addr,
   output logic      [3:0]                     hit
);
   import scfp_pkg::*;
   genvar g;
   generate
      for (g = 0; g < MAX_TCM; g++) begin : g_tcm
         if (g < N_TCM) begin : g_on
            assign hit[g] = ((addr & MASK[g*31 +: 31]) ==
                             BASE[g*31 +: 31]);
         end else begin : g_off
            assign hit[g] = 1'b0;
         end
      end
   endgenerate
endmodule : scfp_tcm_decode
`default_nettype wire

// >>> dv/scfp_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module scfp_core_asserts #(
   parameter int              N_TCM    = 0,
   parameter logic [4*31-1:0] TCM_BASE = '0,
   parameter logic [4*31-1:0] TCM_MASK = '0
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [30:0] im_address,
   input  wire logic        im_read,
   input  wire logic        im_waitrequest,
   input  wire logic [3:0]  tcm_read,
   input  wire logic        dm_waitrequest,
   input  wire logic        ci_stall,
   input  wire logic [4:0]  stage_valid,
   input  wire logic        retire,
   input  wire logic        stall
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic        acc;
   logic        hit0;
   logic [2:0]  acc_n_q;
   logic [30:0] last_q;
   logic [7:0]  run_q;
   assign acc  = im_read & ~im_waitrequest;
   assign hit0 = (N_TCM > 0) &&
                 ((im_address & TCM_MASK[30:0]) == TCM_BASE[30:0]);
   // Beat count inside a line fill
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         acc_n_q <= 3'h0;
      end else if (acc) begin
         acc_n_q <= acc_n_q + 3'h1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (acc) begin
         last_q <= im_address;
      end
   end
   // Stall cycles with no outside cause; the serial shifter caps these
   always_ff @(posedge ref_clk) begin
      if (rst || !stall || dm_waitrequest || ci_stall) begin
         run_q <= 8'h00;
      end else begin
         run_q <= run_q + 8'h01;
      end
   end
   reset_clear_a : assert property (disable iff (1'b0)
      rst |=> (stage_valid == 5'h00 && !stall && !retire && !im_read))
      else $error("outputs not cleared by reset");
   stall_in_mem_a : assert property (stall |-> stage_valid[3])
      else $error("stall without memory stage occupied");
   stall_hold_a : assert property (
      stall |=> $stable(stage_valid[3:0]))
      else $error("earlier stages moved during stall");
   req_hold_a : assert property (
      im_read && im_waitrequest |=> im_read && $stable(im_address))
      else $error("fill request changed before acceptance");
   fill_wrap_a : assert property (
      acc && acc_n_q != 3'h0 |->
      im_address == {last_q[30:5], last_q[4:2] + 3'h1, 2'h0})
      else $error("fill address not next word of line");
   fill_burst_a : assert property (
      acc && acc_n_q != 3'h7 |=> im_read)
      else $error("fill request gap inside a line");
   tcm_onehot_a : assert property ($onehot0(tcm_read))
      else $error("more than one tightly coupled port read");
   tcm_bypass_a : assert property (im_read |-> !hit0)
      else $error("cache fill issued for tightly coupled span");
   stall_bound_a : assert property (run_q < 8'd40)
      else $error("shift or multiply stall too long");
endmodule : scfp_core_asserts
bind scfp_core scfp_core_asserts #(
   .N_TCM(N_TCM), .TCM_BASE(TCM_BASE), .TCM_MASK(TCM_MASK)
) u_chk (
   .ref_clk, .rst, .im_address, .im_read, .im_waitrequest, .tcm_read,
   .dm_waitrequest, .ci_stall, .stage_valid, .retire, .stall
);
`default_nettype wire

// >>> dv/scfp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module scfp_mem_model (
   input  wire logic            ref_clk,
   input  wire logic            rst,
   input  wire logic            slow,
   input  wire logic [30:0]     im_address,
   input  wire logic            im_read,
   output logic                 im_waitrequest,
   output logic                 im_readdatavalid,
   output logic [31:0]          im_readdata,
   input  wire logic [4*31-1:0] tcm_address,
   input  wire logic [3:0]      tcm_read,
   output logic [4*32-1:0]      tcm_readdata
);
   logic [30:0] q_a[$];
   int          q_t[$];
   int          cyc;
   // accepts new reads before older data returns
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (rst) begin
         q_a.delete();
         q_t.delete();
         im_waitrequest <= 1'b0;
         im_readdatavalid <= 1'b0;
         im_readdata <= 32'h0000_0000;
      end else begin
         im_waitrequest <= slow & ~im_waitrequest;
         if (im_read && !im_waitrequest) begin
            q_a.push_back(im_address);
            q_t.push_back(cyc);
         end
         if (q_a.size() > 0 && cyc - q_t[0] >= (slow ? 3 : 0)) begin
            im_readdatavalid <= 1'b1;
            im_readdata <= {1'b1, q_a.pop_front()};
            void'(q_t.pop_front());
         end else begin
            // Idle bus inverts every bit each cycle, so the last word shows again every other idle cycle
            im_readdatavalid <= 1'b0;
            im_readdata <= ~im_readdata;
         end
      end
   end
   always @(posedge ref_clk) begin
      for (int i = 0; i < 4; i++) begin
         tcm_readdata[i*32 +: 32] <= rst ? 32'h0000_0000 :
            tcm_read[i] ? {1'b1, tcm_address[i*31 +: 31]} :
            ~tcm_readdata[i*32 +: 32];
      end
   end
endmodule : scfp_mem_model
`default_nettype wire

// >>> dv/scfp_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module scfp_core_tb;
   import scfp_pkg::*;
   logic           ref_clk, rst, slow, im_read, im_waitrequest;
   logic           im_readdatavalid, ex_taken, dm_waitrequest, ci_stall;
   logic           retire, fetch_word_valid, stall;
   logic [30:0]    im_address, dec_target, ex_target, cm_addr;
   logic [31:0]    im_readdata, dec_disp, fetch_word;
   logic [123:0]   tcm_address;
   logic [127:0]   tcm_readdata;
   logic [3:0]     tcm_read;
   logic [5:0]     dec_shamt;
   logic [4:0]     stage_valid;
   scfp_op_t       dec_op;
   int             error_cnt, compares;
   scfp_core #(.N_TCM(1), .TCM_BASE('0), .TCM_MASK({93'h0, 31'h7FFF_F000}))
   u_dut (.ref_clk, .rst, .im_address, .im_read, .im_waitrequest,
      .im_readdatavalid, .im_readdata, .tcm_address, .tcm_read,
      .tcm_readdata, .dec_op, .dec_disp, .dec_shamt, .dec_target,
      .ex_taken, .ex_target, .cm_addr, .dm_waitrequest, .ci_stall,
      .stage_valid, .retire, .fetch_word, .fetch_word_valid, .stall);
   scfp_mem_model u_mem (.ref_clk, .rst, .slow, .im_address, .im_read,
      .im_waitrequest, .im_readdatavalid, .im_readdata, .tcm_address,
      .tcm_read, .tcm_readdata);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string nm);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic stop_test();
      if (error_cnt == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic do_reset(input scfp_op_t op, input logic [31:0] disp,
                           input logic tk, input logic [30:0] tgt);
      @(negedge ref_clk);
      rst = 1'b1;
      dec_op = op;
      dec_disp = disp;
      ex_taken = tk;
      ex_target = tgt;
      dec_target = tgt;
      dm_waitrequest = 1'b0;
      ci_stall = 1'b0;
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      chk({stage_valid, stall, retire, im_read}, 32'h0, "reset_state");
   endtask : do_reset
   task automatic t_tcm();
      int n;
      do_reset(SCFP_OP_ALU, 32'h10, 1'b0, 31'h40);
      n = 0;
      while (tcm_read[0] !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      chk(tcm_address[30:0], RESET_ADDR, "tcm_addr");
      n = 0;
      while (fetch_word_valid !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      chk(fetch_word, {1'b1, RESET_ADDR}, "tcm_word");
   endtask : t_tcm
   // Steady retire spacing of a stream of one instruction class
   task automatic t_gap(input scfp_op_t op, input logic [31:0] disp,
                        input logic tk, input int exp);
      int n;
      do_reset(op, disp, tk, 31'h40);
      repeat (16) @(negedge ref_clk);
      n = 0;
      while (retire !== 1'b1 && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (retire !== 1'b1 && n < 50);
      chk(n, exp, "retire_gap");
   endtask : t_gap
   task automatic t_hold(input scfp_op_t op, input logic ci);
      logic [4:0] sv;
      logic       seen;
      int         n;
      do_reset(op, 32'h10, 1'b0, 31'h40);
      if (ci)
         ci_stall = 1'b1;
      else
         dm_waitrequest = 1'b1;
      repeat (16) @(negedge ref_clk);
      chk(stall, 1'b1, "stall_on");
      sv = stage_valid;
      seen = 1'b0;
      repeat (5) begin
         @(negedge ref_clk);
         seen = seen | retire;
      end
      chk(stage_valid, sv, "stage_hold");
      chk(seen, 1'b0, "no_retire");
      ci_stall = 1'b0;
      dm_waitrequest = 1'b0;
      n = 0;
      while (retire !== 1'b1 && n < 10) begin
         @(negedge ref_clk);
         n++;
      end
      chk(n < 10, 1'b1, "resume");
   endtask : t_hold
   // Miss on word 5 of a line outside the tightly coupled span
   task automatic t_fill(input logic s);
      int n;
      slow = s;
      do_reset(SCFP_OP_JUMP, 32'h10, 1'b1, 31'h0000_2114);
      for (int i = 0; i < LINE_WORDS; i++) begin
         n = 0;
         while (!(im_read === 1'b1 && im_waitrequest === 1'b0) && n < 200)
         begin
            @(negedge ref_clk);
            n++;
         end
         chk(im_address, 31'h0000_2100 + 31'(((5 + i) % 8) * 4), "fill_addr");
         @(negedge ref_clk);
      end
   endtask : t_fill
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      stop_test();
   end
   initial begin
      rst = 1'b1;
      slow = 1'b0;
      dec_op = SCFP_OP_ALU;
      dec_disp = 32'h0000_0010;
      dec_shamt = 6'h05;
      dec_target = 31'h0000_0040;
      ex_taken = 1'b0;
      ex_target = 31'h0000_0040;
      cm_addr = 31'h0000_0040;
      dm_waitrequest = 1'b0;
      ci_stall = 1'b0;
      t_tcm();
      t_gap(SCFP_OP_ALU, 32'h10, 1'b0, 1);
      t_gap(SCFP_OP_CUSTOM, 32'h10, 1'b0, 1);
      t_gap(SCFP_OP_BRANCH, 32'hFFFF_FFF0, 1'b1, 2);
      t_gap(SCFP_OP_BRANCH, 32'h10, 1'b0, 1);
      t_gap(SCFP_OP_BRANCH, 32'h10, 1'b1, FLUSH_CYCLES);
      t_gap(SCFP_OP_BRANCH, 32'hFFFF_FFF0, 1'b0, FLUSH_CYCLES);
      t_gap(SCFP_OP_FLUSH, 32'h10, 1'b0, FLUSH_CYCLES);
      t_gap(SCFP_OP_JUMP, 32'h10, 1'b1, FLUSH_CYCLES);
      t_gap(SCFP_OP_CACHE, 32'h10, 1'b0, FLUSH_CYCLES);
      t_gap(SCFP_OP_SHIFT, 32'h10, 1'b0, MUL_EMB_CYCLES);
      t_gap(SCFP_OP_MUL, 32'h10, 1'b0, MUL_EMB_CYCLES);
      t_hold(SCFP_OP_LOAD, 1'b0);
      t_hold(SCFP_OP_CUSTOM, 1'b1);
      t_fill(1'b0);
      t_fill(1'b1);
      stop_test();
   end
endmodule : scfp_core_tb
`default_nettype wire
